//--- verilog/pbc_pkg.sv
// Constants and types for the power budgeting capability register bank
// =====================================================================
// Operation
// - The header holds a 16-bit capability identifier in bits 15:0, 0x4 meaning power budgeting, reset to zero.
// - The header holds a 4-bit capability version in bits 19:16, 0x1 meaning version 1, reset to zero.
// - The select register holds an 8-bit read-write selector in bits 7:0 that picks the word shown in the data window.
// - A selector above 9 makes the data window read all zeros.
// - The read-only data window returns the selected data value word, or zero when none is implemented.
// - Bit 0 of the allocation register is a sticky system-allocated flag that resets to zero.
// - The ten 32-bit data value words accept writes only while the unlock bit is set; otherwise writes are dropped.
// - Sticky fields survive a hot reset and clear only on a fundamental reset.
package pbc_pkg;

    // =================================================================
    // Register map, byte addresses
    localparam int unsigned ADDR_W        = 12;
    localparam logic [11:0] OFS_HEADER    = 12'h280;
    localparam logic [11:0] OFS_SELECT    = 12'h284;
    localparam logic [11:0] OFS_WINDOW    = 12'h288;
    localparam logic [11:0] OFS_SYSALLOC  = 12'h28c;
    localparam logic [11:0] OFS_SYSTEM_CONTROL    = 12'h290;
    localparam logic [11:0] OFS_DV_BASE   = 12'h300;
    localparam logic [11:0] OFS_DV_LAST   = 12'h324;

    // =================================================================
    // Fields and values
    localparam int unsigned DV_WORDS      = 10;
    localparam logic [7:0]  SEL_MAX       = 8'h09;
    localparam int unsigned SEL_W         = 8;
    localparam int unsigned SA_BIT        = 0;
    localparam int unsigned UNLOCK_BIT    = 0;
    localparam logic [15:0] CAPABILITY_IDENTIFIER_POWER   = 16'h0004;
    localparam logic [3:0]  CAPABILITY_VERSION_ONE    = 4'h1;
    localparam logic [31:0] HEADER_RST    = 32'h0000_0000;
    localparam logic [7:0]  SEL_RST       = 8'h00;
    localparam logic [31:0] DV_RST        = 32'h0000_0000;
    localparam logic        SA_RST        = 1'b0;
    localparam logic        UNLOCK_RST    = 1'b0;

    // =================================================================
    // Bus answers
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef struct packed {
        logic [11:0] next_capability_pointer;
        logic [3:0]  capability_version;
        logic [15:0] capability_identifier;
    } pbc_header_type;

endpackage

//--- verilog/pbc_regs.sv
// Power budgeting capability register bank with AXI4-Lite slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module pbc_regs (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        rst_fund,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             system_allocated
);

    // =================================================================
    // State
    logic                   aw_have_q, aw_have_d;
    logic [11:0]            awaddr_q, awaddr_d;
    logic                   w_have_q, w_have_d;
    logic [31:0]            wdata_q, wdata_d;
    logic [3:0]             wstrb_q, wstrb_d;
    logic                   awready_q, awready_d;
    logic                   wready_q, wready_d;
    logic                   bvalid_q, bvalid_d;
    logic [1:0]             bresp_q, bresp_d;
    logic                   arready_q, arready_d;
    logic                   rvalid_q, rvalid_d;
    logic [31:0]            rdata_q, rdata_d;
    logic [1:0]             rresp_q, rresp_d;
    pbc_pkg::pbc_header_type hdr_q, hdr_d;
    logic [7:0]             sel_q, sel_d;
    logic                   unlock_q, unlock_d;
    logic                   sa_q, sa_d;
    logic [9:0][31:0]       dv_q, dv_d;

    logic                   aw_take, w_take, ar_take, commit;
    logic [31:0]            rd_val;
    logic                   rd_hit;
    logic [31:0]            window_val;

    assign aw_take = s_axi_awvalid && awready_q;
    assign w_take  = s_axi_wvalid && wready_q;
    assign ar_take = s_axi_arvalid && arready_q;
    assign commit  = aw_have_q && w_have_q && !bvalid_q;

    assign s_axi_awready    = awready_q;
    assign s_axi_wready     = wready_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = arready_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;
    assign system_allocated = sa_q;

    function automatic logic [31:0] pbc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic pbc_dv_hit(input logic [11:0] a);
        return (a >= pbc_pkg::OFS_DV_BASE) && (a <= pbc_pkg::OFS_DV_LAST);
    endfunction

    function automatic logic [3:0] pbc_dv_idx(input logic [11:0] a);
        logic [11:0] off;
        off = a - pbc_pkg::OFS_DV_BASE;
        return off[5:2];
    endfunction

    // =================================================================
    // Read decode
    always_comb begin
        window_val = '0;
        if (sel_q <= pbc_pkg::SEL_MAX) begin
            window_val = dv_q[sel_q[3:0]];
        end
        rd_val = '0;
        rd_hit = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            pbc_pkg::OFS_HEADER:   rd_val = hdr_q;
            pbc_pkg::OFS_SELECT:   rd_val = {24'h000000, sel_q};
            pbc_pkg::OFS_WINDOW:   rd_val = window_val;
            pbc_pkg::OFS_SYSALLOC: rd_val = {31'h00000000, sa_q};
            pbc_pkg::OFS_SYSTEM_CONTROL:   rd_val = {31'h00000000, unlock_q};
            default: begin
                if (pbc_dv_hit({s_axi_araddr[11:2], 2'b00})) begin
                    rd_val = dv_q[pbc_dv_idx(s_axi_araddr)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // =================================================================
    // Next values
    always_comb begin
        aw_have_d = aw_have_q;
        awaddr_d  = awaddr_q;
        w_have_d  = w_have_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        hdr_d     = hdr_q;
        sel_d     = sel_q;
        unlock_d  = unlock_q;
        sa_d      = sa_q;
        dv_d      = dv_q;
        if (aw_take) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (w_take) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (commit) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = pbc_pkg::RESP_OKAY;
            case ({awaddr_q[11:2], 2'b00})
                pbc_pkg::OFS_HEADER: begin
                    if (unlock_q) begin
                        hdr_d = pbc_merge(hdr_q, wdata_q, wstrb_q);
                    end
                end
                pbc_pkg::OFS_SELECT: begin
                    if (wstrb_q[0]) begin
                        sel_d = wdata_q[7:0];
                    end
                end
                pbc_pkg::OFS_WINDOW: begin
                end
                pbc_pkg::OFS_SYSALLOC: begin
                    if (unlock_q && wstrb_q[0]) begin
                        sa_d = wdata_q[pbc_pkg::SA_BIT];
                    end
                end
                pbc_pkg::OFS_SYSTEM_CONTROL: begin
                    if (wstrb_q[0]) begin
                        unlock_d = wdata_q[pbc_pkg::UNLOCK_BIT];
                    end
                end
                default: begin
                    if (pbc_dv_hit({awaddr_q[11:2], 2'b00})) begin
                        if (unlock_q) begin
                            dv_d[pbc_dv_idx(awaddr_q)] =
                                pbc_merge(dv_q[pbc_dv_idx(awaddr_q)], wdata_q, wstrb_q);
                        end
                    end else begin
                        bresp_d = pbc_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (ar_take) begin
            rvalid_d = 1'b1;
            rdata_d  = rd_val;
            rresp_d  = rd_hit ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    // =================================================================
    // Bus and plain registers: cleared by either reset
    always_ff @(posedge mclk) begin
        if (rst || rst_fund) begin
            aw_have_q <= 1'b0;
            awaddr_q  <= '0;
            w_have_q  <= 1'b0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= pbc_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= pbc_pkg::RESP_OKAY;
            hdr_q     <= pbc_pkg::HEADER_RST;
            sel_q     <= pbc_pkg::SEL_RST;
            unlock_q  <= pbc_pkg::UNLOCK_RST;
        end else if (ce) begin
            aw_have_q <= aw_have_d;
            awaddr_q  <= awaddr_d;
            w_have_q  <= w_have_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            hdr_q     <= hdr_d;
            sel_q     <= sel_d;
            unlock_q  <= unlock_d;
        end
    end

    // =================================================================
    // Sticky registers: fundamental reset only
    always_ff @(posedge mclk) begin
        if (rst_fund) begin
            sa_q <= pbc_pkg::SA_RST;
            dv_q <= {pbc_pkg::DV_WORDS{pbc_pkg::DV_RST}};
        end else if (ce && !rst) begin
            sa_q <= sa_d;
            dv_q <= dv_d;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || rst_fund);

    property p_hdr_reset;
        $fell(rst) |-> hdr_q == pbc_pkg::HEADER_RST;
    endproperty
    a_hdr_reset: assert property (p_hdr_reset) else $error("header not zero after reset");

    property p_hdr_locked;
        (ce && commit && {awaddr_q[11:2], 2'b00} == pbc_pkg::OFS_HEADER && !unlock_q)
            |=> hdr_q == $past(hdr_q);
    endproperty
    a_hdr_locked: assert property (p_hdr_locked) else $error("locked header changed");

    property p_sel_write;
        (ce && commit && {awaddr_q[11:2], 2'b00} == pbc_pkg::OFS_SELECT && wstrb_q[0])
            |=> sel_q == $past(wdata_q[7:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("selector not written");

    sequence s_win_read;
        ce && ar_take && {s_axi_araddr[11:2], 2'b00} == pbc_pkg::OFS_WINDOW;
    endsequence

    property p_win_zero;
        (s_win_read and (sel_q > pbc_pkg::SEL_MAX)) |=> rvalid_q && rdata_q == 32'h0;
    endproperty
    a_win_zero: assert property (p_win_zero) else $error("window not zero");

    property p_win_data;
        (s_win_read and (sel_q <= pbc_pkg::SEL_MAX))
            |=> rvalid_q && rdata_q == $past(dv_q[sel_q[3:0]]);
    endproperty
    a_win_data: assert property (p_win_data) else $error("window word wrong");

    property p_sa_reset;
        $fell(rst_fund) |-> !sa_q;
    endproperty
    a_sa_reset: assert property (p_sa_reset) else $error("flag not cleared");

    property p_dv_locked;
        (ce && commit && pbc_dv_hit({awaddr_q[11:2], 2'b00}) && !unlock_q)
            |=> dv_q == $past(dv_q);
    endproperty
    a_dv_locked: assert property (p_dv_locked) else $error("locked word changed");

    property p_sticky;
        @(posedge mclk) disable iff (rst_fund)
        rst |=> sa_q == $past(sa_q) && dv_q == $past(dv_q);
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky lost on hot reset");

    property p_sel_reserved;
        (ce && ar_take && {s_axi_araddr[11:2], 2'b00} == pbc_pkg::OFS_SELECT)
            |=> rvalid_q && rdata_q[31:8] == 24'h0;
    endproperty
    a_sel_reserved: assert property (p_sel_reserved) else $error("reserved bits set");

endmodule

//--- test/pbc_regs_bench.sv
// Self-checking bench for the power budgeting capability register bank
`timescale 1ns/1ps
module pbc_regs_bench;
    logic        mclk;
    logic        rst;
    logic        rst_fund;
    logic        ce;
    logic [11:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        sys_alloc;
    int          err_count;
    int          check_count;

    pbc_regs u_pbc_regs (
        .mclk(mclk), .rst(rst), .rst_fund(rst_fund), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .system_allocated(sys_alloc)
    );

    // =================================================================
    // Clock, checks and bus cycles
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk(nm, exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task automatic pulse_reset(input logic fund);
        @(posedge mclk);
        rst      <= 1'b1;
        rst_fund <= fund;
        repeat (2) @(posedge mclk);
        rst      <= 1'b0;
        rst_fund <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    function automatic logic [31:0] dv(input int i);
        return 32'h1357_9bd0 ^ (32'h0101_0101 * 32'(i));
    endfunction

    function automatic logic [11:0] dv_addr(input int i);
        return pbc_pkg::OFS_DV_BASE + 12'(i * 4);
    endfunction

    // =================================================================
    // Scenarios
    task automatic t_reset_values;
        rd_chk("header", pbc_pkg::OFS_HEADER, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("select", pbc_pkg::OFS_SELECT, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("window", pbc_pkg::OFS_WINDOW, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("flag", pbc_pkg::OFS_SYSALLOC, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("unmapped", 12'h2a0, 32'h0, pbc_pkg::RESP_SLVERR);
        wr(12'h2a0, 32'hffff_ffff, pbc_pkg::RESP_SLVERR);
    endtask

    task automatic t_locked;
        wr(pbc_pkg::OFS_HEADER, 32'h1234_5678, pbc_pkg::RESP_OKAY);
        rd_chk("locked header", pbc_pkg::OFS_HEADER, 32'h0, pbc_pkg::RESP_OKAY);
        wr(dv_addr(0), 32'hcafe_f00d, pbc_pkg::RESP_OKAY);
        rd_chk("locked word", dv_addr(0), 32'h0, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_SYSALLOC, 32'h1, pbc_pkg::RESP_OKAY);
        chk("system_allocated", 32'h0, {31'h0, sys_alloc});
    endtask

    task automatic t_fields;
        wr(pbc_pkg::OFS_SYSTEM_CONTROL, 32'h1, pbc_pkg::RESP_OKAY);
        rd_chk("unlock", pbc_pkg::OFS_SYSTEM_CONTROL, 32'h1, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_HEADER, 32'h3281_0004, pbc_pkg::RESP_OKAY);
        rd_chk("header", pbc_pkg::OFS_HEADER, 32'h3281_0004, pbc_pkg::RESP_OKAY);
        wstrb <= 4'hc;
        wr(pbc_pkg::OFS_HEADER, 32'h0000_ffff, pbc_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd_chk("header bytes", pbc_pkg::OFS_HEADER, 32'h0000_0004, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_SELECT, 32'hffff_ff05, pbc_pkg::RESP_OKAY);
        rd_chk("select", pbc_pkg::OFS_SELECT, 32'h05, pbc_pkg::RESP_OKAY);
        wstrb <= 4'he;
        wr(pbc_pkg::OFS_SELECT, 32'h0000_0009, pbc_pkg::RESP_OKAY);
        wstrb <= 4'hf;
        rd_chk("select no byte0", pbc_pkg::OFS_SELECT, 32'h05, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_SYSALLOC, 32'hffff_ffff, pbc_pkg::RESP_OKAY);
        rd_chk("flag", pbc_pkg::OFS_SYSALLOC, 32'h1, pbc_pkg::RESP_OKAY);
        chk("system_allocated", 32'h1, {31'h0, sys_alloc});
    endtask

    task automatic t_window;
        for (int i = 0; i < 10; i++) wr(dv_addr(i), dv(i), pbc_pkg::RESP_OKAY);
        for (int i = 0; i < 10; i++) begin
            wr(pbc_pkg::OFS_SELECT, 32'(i), pbc_pkg::RESP_OKAY);
            rd_chk("window", pbc_pkg::OFS_WINDOW, dv(i), pbc_pkg::RESP_OKAY);
        end
        wr(pbc_pkg::OFS_SELECT, 32'd10, pbc_pkg::RESP_OKAY);
        rd_chk("window sel 10", pbc_pkg::OFS_WINDOW, 32'h0, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_SELECT, 32'hff, pbc_pkg::RESP_OKAY);
        rd_chk("window sel 255", pbc_pkg::OFS_WINDOW, 32'h0, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_SELECT, 32'd3, pbc_pkg::RESP_OKAY);
        wr(pbc_pkg::OFS_WINDOW, 32'hdead_beef, pbc_pkg::RESP_OKAY);
        rd_chk("window ro", pbc_pkg::OFS_WINDOW, dv(3), pbc_pkg::RESP_OKAY);
    endtask

    task automatic t_freeze;
        @(posedge mclk);
        awaddr  <= pbc_pkg::OFS_SELECT;
        wdata   <= 32'h0000_0007;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        @(posedge mclk);
        chk("readies", 32'h3, {30'h0, awready, wready});
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        ce      <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("frozen bvalid", 32'h0, {31'h0, bvalid});
        ce <= 1'b1;
        while (!bvalid) @(posedge mclk);
        bready <= 1'b0;
        chk("bresp", {30'h0, pbc_pkg::RESP_OKAY}, {30'h0, bresp});
        rd_chk("select thawed", pbc_pkg::OFS_SELECT, 32'h07, pbc_pkg::RESP_OKAY);
    endtask

    task automatic t_resets;
        pulse_reset(1'b0);
        rd_chk("header", pbc_pkg::OFS_HEADER, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("select", pbc_pkg::OFS_SELECT, 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("flag hot", pbc_pkg::OFS_SYSALLOC, 32'h1, pbc_pkg::RESP_OKAY);
        chk("system_allocated", 32'h1, {31'h0, sys_alloc});
        rd_chk("word hot", dv_addr(2), dv(2), pbc_pkg::RESP_OKAY);
        wr(dv_addr(2), 32'h0, pbc_pkg::RESP_OKAY);
        rd_chk("word relocked", dv_addr(2), dv(2), pbc_pkg::RESP_OKAY);
        pulse_reset(1'b1);
        rd_chk("flag fund", pbc_pkg::OFS_SYSALLOC, 32'h0, pbc_pkg::RESP_OKAY);
        chk("system_allocated", 32'h0, {31'h0, sys_alloc});
        rd_chk("word fund", dv_addr(9), 32'h0, pbc_pkg::RESP_OKAY);
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        rst      = 1'b1;
        rst_fund = 1'b1;
        ce       = 1'b1;
        awaddr   = 12'h000;
        awvalid  = 1'b0;
        wdata    = 32'h0;
        wstrb    = 4'hf;
        wvalid   = 1'b0;
        bready   = 1'b0;
        araddr   = 12'h000;
        arvalid  = 1'b0;
        rready   = 1'b0;
        err_count   = 0;
        check_count = 0;
        repeat (6) @(posedge mclk);
        rst      <= 1'b0;
        rst_fund <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset_values();
        t_locked();
        t_fields();
        t_window();
        t_freeze();
        t_resets();
        finish_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        finish_test();
    end
endmodule
